// *** design/oct_pkg.sv ***
`default_nettype none
package oct_pkg;
    // Register offsets, one aligned 32-bit word each, data in bits 7:0 (compare words in bits 15:0)
    localparam logic [7:0] A_FORCE = 8'h00;
    localparam logic [7:0] A_MASK  = 8'h04;
    localparam logic [7:0] A_DATA  = 8'h08;
    localparam logic [7:0] A_CNTHI = 8'h0c;
    localparam logic [7:0] A_CNTLO = 8'h10;
    localparam logic [7:0] A_ACT   = 8'h14;
    localparam logic [7:0] A_IEN1  = 8'h18;
    localparam logic [7:0] A_FLG1  = 8'h1c;
    localparam logic [7:0] A_IEN2  = 8'h20;
    localparam logic [7:0] A_FLG2  = 8'h24;
    localparam logic [7:0] A_AUX   = 8'h28;
    localparam logic [7:0] A_CMP1  = 8'h30;
    localparam logic [7:0] A_CMP5  = 8'h40;

    // Field positions
    localparam int F_TOF    = 7;
    localparam int F_PERIODIC_FLAG   = 6;
    localparam int F_SHF    = 3;
    localparam int F_SHSEL  = 2;

    // Implemented-bit masks
    localparam logic [7:0] M_HI5  = 8'hf8;
    localparam logic [7:0] M_IEN2 = 8'hf3;
    localparam logic [7:0] M_FLG2 = 8'hc0;
    localparam logic [7:0] M_AUX  = 8'h07;

    // Reset values and count maximum
    localparam logic [15:0] CMP_RST  = 16'hffff;
    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [15:0] CNT_MAX  = 16'hffff;

    // Timing counts
    localparam int PRE_WIN_CYC  = 64;
    localparam int RTI_BASE_LOG = 13;

    typedef enum logic [1:0] {
        PRE_OPEN = 2'b01,
        PRE_SHUT = 2'b10
    } oct_pre_e;

    typedef struct packed {
        logic [7:3] lvl;
        logic [7:3] oe;
    } oct_pin_s;
endpackage
`default_nettype wire

// *** design/oct_timer.sv ***
// Summary of operation
// - Writing one to a force bit triggers that channel's pin action.
// - Channel-one mask bits 7..3 let channel one drive port pins 7..3.
// - Channel-one match copies data bits to pins wherever mask is set.
// - Unimplemented bits of force, mask, data, flag2, enable2 read zero.
// - Free-running count is 16-bit, prescaled, and read-only.
// - Reading count high byte latches low byte for a coherent pair.
// - Mode/level pairs: 00 off, 01 toggle, 10 clear, 11 set.
// - Channel five compares only while shared-channel select is clear.
// - Enable bits match flags bit for bit; enabled set flag requests irq.
// - Shared enable gates capture four or compare five per select.
// - Flags clear when software writes one to their bit.
// - Compare flag sets whenever count equals channel compare value.
// - Shared flag set by capture four or compare five per select.
// - Capture flags one to three set on detected active edge.
// - Overflow enable one requests irq while overflow flag set.
// - Prescale codes 00..11 divide counter clock by 1, 4, 8, 16.
// - Prescale field takes one write only, within 64 cycles of reset.
// - Overflow flag sets when count rolls from all ones to zero.
// - Periodic period is 2^13, 2^14, 2^15 or 2^16 bus cycles.
// - Periodic timebase runs freely; periods count from reset, not from a rate write.
// - Each periodic timeout sets periodic flag; enable raises irq.
// - First periodic flag comes one full period after reset.
// - Forced compare acts at next count tick and sets no flag.
// - Pin action taken on every match regardless of flag state.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module oct_timer
    import oct_pkg::*;
#(
    parameter int RTI_SHIFT = RTI_BASE_LOG,
    parameter int PRE_WIN   = PRE_WIN_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  cap_evt_i,
    output var oct_pin_s     pins_o,
    output logic             irq_o
);
    localparam int RW = RTI_SHIFT + 3;

    logic        ack_r;
    logic [31:0] dat_r;
    logic        req;
    logic        acc;
    logic        wr0;
    logic        wr1;
    logic        rd;
    logic [7:0]  wd;
    logic [7:0]  rdata;

    logic [7:0]  mask_r;
    logic [7:0]  data_r;
    logic [7:0]  act_r;
    logic [7:0]  ien1_r;
    logic [7:0]  flg1_r;
    logic [7:0]  ien2_r;
    logic [7:0]  flg2_r;
    logic [2:0]  aux_r;
    logic [15:0] cmp_r [5];

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0]  lo_buf_r;
    logic        lo_hold_r;
    logic [3:0]  pre_r;
    logic [3:0]  pre_lim;
    logic        tick;
    oct_pre_e    pst_r;
    logic [6:0]  win_r;

    logic [4:0]  foc_r;
    logic [4:0]  match;
    logic [4:0]  act;
    logic [7:0]  set1;
    logic        shsel;

    logic [RW-1:0] rti_r;
    logic [RW-1:0] rti_msk;
    logic          rto;

    logic [7:3]  pa_r;
    logic [7:3]  pa_nxt;
    logic [7:3]  oe_r;
    logic [7:3]  oe_nxt;
    logic        irq_r;

    // Bus decode: side effects land on the edge that samples ack
    assign req   = wb_cyc_i & wb_stb_i;
    assign acc   = req & ack_r;
    assign wr0   = acc & wb_we_i & wb_sel_i[0];
    assign wr1   = acc & wb_we_i & wb_sel_i[1];
    assign rd    = acc & ~wb_we_i;
    assign wd    = wb_dat_i[7:0];
    assign shsel = aux_r[F_SHSEL];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_comb begin
        rdata = 8'h00;
        case (wb_adr_i)
            A_MASK:  rdata = mask_r & M_HI5;
            A_DATA:  rdata = data_r & M_HI5;
            A_CNTHI: rdata = cnt_r[15:8];
            A_CNTLO: rdata = lo_hold_r ? lo_buf_r : cnt_r[7:0];
            A_ACT:   rdata = act_r;
            A_IEN1:  rdata = ien1_r;
            A_FLG1:  rdata = flg1_r;
            A_IEN2:  rdata = ien2_r & M_IEN2;
            A_FLG2:  rdata = flg2_r & M_FLG2;
            A_AUX:   rdata = {5'h00, aux_r};
            default: rdata = 8'h00;
        endcase
    end

    // Compare words carry 16 bits; everything else reads from rdata
    logic [15:0] cmp_rd;
    logic        cmp_hit;

    always_comb begin
        cmp_rd  = 16'h0000;
        cmp_hit = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (wb_adr_i == A_CMP1 + 8'(4 * i)) begin
                cmp_rd  = cmp_r[i];
                cmp_hit = 1'b1;
            end
        end
    end

    // Whole read word registered, so the data output is a flop
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dat_r <= 32'h0000_0000;
        end else if (req & ~ack_r) begin
            dat_r <= cmp_hit ? {16'h0000, cmp_rd}
                             : {24'h00_0000, rdata};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Plain control registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_r <= BYTE_RST;
            data_r <= BYTE_RST;
            act_r  <= BYTE_RST;
            ien1_r <= BYTE_RST;
            aux_r  <= 3'b000;
        end else if (wr0) begin
            case (wb_adr_i)
                A_MASK: mask_r <= wd & M_HI5;
                A_DATA: data_r <= wd & M_HI5;
                A_ACT:  act_r  <= wd;
                A_IEN1: ien1_r <= wd;
                A_AUX:  aux_r  <= wd[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 5; i++) begin
                cmp_r[i] <= CMP_RST;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (wb_adr_i == A_CMP1 + 8'(4 * i)) begin
                    if (wr0) cmp_r[i][7:0]  <= wd;
                    if (wr1) cmp_r[i][15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // Prescale field: one write, and only inside the boot window
    always_ff @(posedge clk) begin
        if (!rstn) begin
            win_r  <= 7'd0;
            pst_r  <= PRE_OPEN;
            ien2_r <= BYTE_RST;
        end else begin
            if (win_r != 7'(PRE_WIN)) begin
                win_r <= win_r + 7'd1;
            end
            if (wr0 && wb_adr_i == A_IEN2) begin
                ien2_r[7:4] <= wd[7:4];
            end
            case (pst_r)
                PRE_OPEN: begin
                    if (wr0 && wb_adr_i == A_IEN2) begin
                        ien2_r[1:0] <= wd[1:0];
                        pst_r       <= PRE_SHUT;
                    end else if (win_r == 7'(PRE_WIN)) begin
                        pst_r <= PRE_SHUT;
                    end
                end
                PRE_SHUT: pst_r <= PRE_SHUT;
                default:  pst_r <= PRE_SHUT;
            endcase
        end
    end

    // Prescaler and free-running count
    always_comb begin
        case (ien2_r[1:0])
            2'b00:   pre_lim = 4'h0;
            2'b01:   pre_lim = 4'h3;
            2'b10:   pre_lim = 4'h7;
            default: pre_lim = 4'hf;
        endcase
    end

    assign tick    = (pre_r >= pre_lim);
    assign cnt_nxt = cnt_r + 16'h0001;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pre_r <= 4'h0;
            cnt_r <= 16'h0000;
        end else begin
            pre_r <= tick ? 4'h0 : pre_r + 4'h1;
            if (tick) begin
                cnt_r <= cnt_nxt;
            end
        end
    end

    // Coherent pair: low byte frozen at the high-byte read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lo_buf_r  <= 8'h00;
            lo_hold_r <= 1'b0;
        end else begin
            // Same edge that loads the high byte, else the pair can tear
            if (req && !ack_r && !wb_we_i && wb_adr_i == A_CNTHI) begin
                lo_buf_r <= cnt_r[7:0];
            end
            if (acc) begin
                lo_hold_r <= rd && wb_adr_i == A_CNTHI;
            end
        end
    end

    // Matches sampled at the count transition, once per count value
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_cmp
            assign match[g] = tick && (cnt_nxt == cmp_r[g]);
            assign act[g]   = match[g] | (tick & foc_r[g]);
        end
    endgenerate

    // Force requests wait for the next tick
    always_ff @(posedge clk) begin
        if (!rstn) begin
            foc_r <= 5'b00000;
        end else begin
            if (tick) begin
                foc_r <= 5'b00000;
            end
            if (wr0 && wb_adr_i == A_FORCE) begin
                // Bit 7 forces channel one, which sits at index 0
                foc_r <= foc_r | {wd[3], wd[4], wd[5], wd[6], wd[7]};
            end
        end
    end

    // Flag sources: compares 1..4, shared, captures 1..3
    assign set1 = {match[0], match[1], match[2], match[3],
                   shsel ? cap_evt_i[3] : match[4],
                   cap_evt_i[0], cap_evt_i[1], cap_evt_i[2]};

    // Set beats a same-cycle clear so no event is lost
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flg1_r <= BYTE_RST;
        end else begin
            flg1_r <= (flg1_r & ~((wr0 && wb_adr_i == A_FLG1) ? wd
                       : 8'h00)) | set1;
        end
    end

    // Periodic timebase never restarts except at reset
    always_comb begin
        rti_msk = RW'((1 << (RTI_SHIFT + 32'(aux_r[1:0]))) - 1);
    end

    assign rto = (rti_r & rti_msk) == rti_msk;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rti_r <= '0;
        end else begin
            rti_r <= rti_r + RW'(1);
        end
    end

    logic [7:0] set2;
    assign set2 = {tick && cnt_r == CNT_MAX, rto, 6'h00};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flg2_r <= BYTE_RST;
        end else begin
            flg2_r <= ((flg2_r & ~((wr0 && wb_adr_i == A_FLG2) ? wd
                       : 8'h00)) | set2) & M_FLG2;
        end
    end

    // Pin actions; channel one applied last so it wins shared pins
    always_comb begin
        pa_nxt = pa_r;
        oe_nxt = mask_r[7:3];
        for (int k = 1; k < 5; k++) begin
            if (k < 4 || !shsel) begin
                if (act_r[9-2*k -: 2] != 2'b00) begin
                    oe_nxt[7-k] = 1'b1;
                end
                if (act[k]) begin
                    case (act_r[9-2*k -: 2])
                        2'b01:   pa_nxt[7-k] = ~pa_r[7-k];
                        2'b10:   pa_nxt[7-k] = 1'b0;
                        2'b11:   pa_nxt[7-k] = 1'b1;
                        default: pa_nxt[7-k] = pa_r[7-k];
                    endcase
                end
            end
        end
        if (act[0]) begin
            pa_nxt = (pa_nxt & ~mask_r[7:3])
                   | (data_r[7:3] & mask_r[7:3]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pa_r <= 5'b00000;
            oe_r <= 5'b00000;
        end else begin
            pa_r <= pa_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign pins_o.lvl = pa_r;
    assign pins_o.oe  = oe_r;

    // Shared enable follows its flag position, so one term covers both uses
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flg1_r & ien1_r)
                   | (flg2_r[F_TOF] & ien2_r[F_TOF])
                   | (flg2_r[F_PERIODIC_FLAG] & ien2_r[F_PERIODIC_FLAG]);
        end
    end

    assign irq_o = irq_r;
endmodule // oct_timer
`default_nettype wire

// *** tb/oct_timer_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module oct_timer_assertions
    import oct_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  cap_evt_i,
    input wire oct_pin_s    pins_o,
    input wire logic        irq_o
);
    logic       wr_ok;
    logic       rd_ok;
    logic [7:0] msk_r;
    logic       en1_r;
    logic       en2_r;
    assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ok = wb_ack_o && !wb_we_i;
    // Shadows of what software wrote, taken at the ack edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            msk_r <= 8'h00;
            en1_r <= 1'b0;
            en2_r <= 1'b0;
        end else if (wr_ok) begin
            if (wb_adr_i == A_MASK) msk_r <= wb_dat_i[7:0];
            if (wb_adr_i == A_IEN1) en1_r <= |wb_dat_i[7:0];
            if (wb_adr_i == A_IEN2) en2_r <= |wb_dat_i[7:6];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
    property p_rst_quiet;
        $rose(rstn) |-> !wb_ack_o && !irq_o && pins_o.oe == 5'h00;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset state");
    property p_low3;
        rd_ok && (wb_adr_i == A_FORCE || wb_adr_i == A_DATA)
            |-> wb_dat_o[2:0] == 3'h0;
    endproperty
    a_low3: assert property (p_low3) else $error("low bits set");
    property p_flg2;
        rd_ok && wb_adr_i == A_FLG2 |-> wb_dat_o[3:0] == 4'h0;
    endproperty
    a_flg2: assert property (p_flg2) else $error("flag2 low bits");
    property p_ien2;
        rd_ok && wb_adr_i == A_IEN2 |-> wb_dat_o[3:2] == 2'h0;
    endproperty
    a_ien2: assert property (p_ien2) else $error("enable2 bits");
    property p_mask_rb;
        rd_ok && wb_adr_i == A_MASK |-> wb_dat_o == {24'h0, msk_r & M_HI5};
    endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask read");
    // Past and present both set, so one cycle of output latency is allowed
    property p_mask_oe;
        (msk_r[7:4] & $past(msk_r[7:4]) & ~pins_o.oe[7:4]) == 4'h0;
    endproperty
    a_mask_oe: assert property (p_mask_oe) else $error("mask oe");
    property p_irq_src;
        irq_o |-> $past(en1_r) || $past(en2_r);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq no enable");
    c_force: cover property (wr_ok && wb_adr_i == A_FORCE);
    c_cnt: cover property (rd_ok && wb_adr_i == A_CNTHI);
    c_irq: cover property ($rose(irq_o));
endmodule // oct_timer_assertions
`default_nettype wire

// *** tb/oct_timer_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module oct_timer_test
    import oct_pkg::*;
;
    logic        clk, rstn, cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel, cap;
    logic [31:0] dat, dat_o, q;
    logic [15:0] c0, c1;
    oct_pin_s    pins;
    int          errors, compares, cycles, t1, g;
    logic [7:0]  ra [9] = '{A_FORCE, A_MASK, A_DATA, A_ACT, A_IEN1,
                            A_FLG1, A_IEN2, A_AUX, 8'hfc};
    oct_timer #(.RTI_SHIFT(4), .PRE_WIN(64)) u_oct_timer (
        .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .cap_evt_i(cap),
        .pins_o(pins), .irq_o(irq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'h1);
    endtask
    task automatic rdc(output logic [15:0] c);
        acc(1'b0, A_CNTHI, 32'h0, 4'h1);
        c[15:8] = q[7:0];
        acc(1'b0, A_CNTLO, 32'h0, 4'h1);
        c[7:0] = q[7:0];
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        cap <= v;
        @(posedge clk);
        cap <= 4'h0;
    endtask
    // Clear the periodic flag, then stamp the next rise of the request
    task automatic wirq(output int t);
        wr(A_FLG2, 32'h40);
        repeat (2) @(posedge clk);
        while (irq !== 1'b1) @(posedge clk);
        t = cycles;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 4'h1);
        chk(q, e);
    endtask
    initial begin
        {rstn, cyc, stb, we, adr, sel, dat, cap} = '0;
        {errors, compares, cycles} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rchk(A_FLG2, 32'h0);
        foreach (ra[i]) rchk(ra[i], 32'h0);
        rchk(A_CMP1, {16'h0, CMP_RST});
        wr(A_IEN2, 32'h0e);
        rchk(A_IEN2, 32'h02);
        wr(A_IEN2, 32'h03);
        rchk(A_IEN2, 32'h02);
        // Count writes inside the window must not disturb the rate
        rdc(c0);
        wr(A_CNTHI, 32'h0);
        wr(A_CNTLO, 32'h0);
        repeat (796) @(posedge clk);
        rdc(c1);
        chk({31'h0, (c1 - c0) inside {16'd100, 16'd101}}, 32'h1);
        wr(A_MASK, 32'hff);
        rchk(A_MASK, 32'hf8);
        wr(A_DATA, 32'hab);
        rchk(A_DATA, 32'ha8);
        wr(A_FORCE, 32'h80);
        repeat (12) @(posedge clk);
        chk({22'h0, pins}, {22'h0, 5'b10101, 5'b11111});
        rchk(A_FLG1, 32'h0);
        wr(A_MASK, 32'h0);
        wr(A_ACT, 32'h6d);
        wr(A_FORCE, 32'h78);
        repeat (12) @(posedge clk);
        chk({22'h0, pins}, {22'h0, 5'b11010, 5'b01111});
        wr(A_AUX, 32'h04);
        wr(A_FORCE, 32'h08);
        repeat (12) @(posedge clk);
        chk({22'h0, pins}, {22'h0, 5'b11010, 5'b01110});
        pulse(4'h8);
        rchk(A_FLG1, 32'h08);
        wr(A_IEN1, 32'h08);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(A_FLG1, 32'h0);
        rchk(A_FLG1, 32'h08);
        wr(A_FLG1, 32'h08);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(A_IEN1, 32'h0);
        wr(A_AUX, 32'h0);
        pulse(4'h8);
        pulse(4'h1);
        rchk(A_FLG1, 32'h04);
        rdc(c0);
        acc(1'b1, A_CMP1 + 8'h04, {16'h0, c0 + 16'd20}, 4'h3);
        repeat (200) @(posedge clk);
        rchk(A_FLG1, 32'h44);
        chk({31'h0, pins.lvl[6]}, 32'h0);
        wr(A_FLG1, 32'h40);
        rchk(A_FLG1, 32'h04);
        wr(A_IEN2, 32'h40);
        for (int r = 0; r < 4; r++) begin
            wr(A_AUX, r);
            wirq(t1);
            wirq(t1);
            wirq(g);
            chk(g - t1, 16 << r);
        end
        stop_test();
    end
endmodule // oct_timer_test
bind oct_timer oct_timer_assertions u_oct_timer_assertions (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cap_evt_i(cap_evt_i), .pins_o(pins_o), .irq_o(irq_o));
`default_nettype wire
